// file: design/opts_core.sv
// How it works
// (RULE1) Clear command resets latched over-voltage, under-voltage and transition faults.
// (RULE2) A latch stays set while its fault condition is still present.
// (RULE3) After a clear the output state follows the recovery setting.
// (RULE4) Safe recovery leaves output off; automatic restores the pre-fault state.
// (RULE5) Transition mode: 0 off, 1 arm on current regulation, 2 on voltage.
// (RULE6) Entry into the selected mode turns output off after delay, latching a fault.
// (RULE7) Delay is 0.1 s to 25.5 s in 0.1 s units from the entry event.
// (RULE8) A requested delay is rounded to the nearest 100 ms step.
// (RULE9) Leaving the selected mode before expiry cancels the timer, no fault.
// (RULE10) User output one conducts at bit 0, is off at 1; reads return bit.
// (RULE11) User output two behaves the same from its own bit.
// (RULE12) Trigger mode: 0 off, 1 per-write strobe, 2 event trigger.
// (RULE13) No sequence, event mode: trigger on every output on/off change.
// (RULE14) No sequence, strobe mode: pulse on every output parameter write.
// (RULE15) Sequence loaded, event mode: trigger when the whole sequence completes.
// (RULE16) Sequence loaded, strobe mode: pulse at the end of every step.
// (RULE17) Iteration count takes 1 to 9999; above 9999 means endless.
// (RULE18) Count read returns the count, or the endless mark above 9999.
// (RULE19) Pass count advances per full pass; stops at the count unless endless.
// (RULE20) Current table holds up to 100 points, read back in order.
// (RULE21) Each current point is clamped to the current programming range.
// (RULE22) Dwell table holds 100 times, 1 ms to 129600 s, each held per point.
// (RULE23) Host waits about 100 ms after loading long tables.
// (RULE24) Current write zeroes other point tables; dwell write zeroes wave times. Here each write only sets a status flag (otherZero, waveTimeZero).
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "opts_defs.svh"

module opts_core #(
  parameter int          DEPTH     = 100,
  parameter logic [15:0] I_MAX     = 16'h03E8,
  parameter logic [15:0] MS_CYCLES = 16'(`OPTS_MS_NS / `OPTS_CLK_NS)
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Register port
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic [31:0]             regRdata,
  // Power stage
  input  wire logic               ovCond,
  input  wire logic               uvCond,
  input  wire logic [1:0]         regMode,
  output logic                    powerOn,
  output logic [15:0]             voltageSet,
  output logic [15:0]             currentSet,
  // Rear panel
  output logic                    trigOut,
  input  wire logic [1:0]         userPinIn,
  output opts_pkg::opts_pins_t    userPins
);

  opts_pkg::opts_state_t st;
  opts_pkg::opts_state_t nxt;

  logic [15:0] curTbl [DEPTH];
  logic [26:0] dwlTbl [DEPTH];

  logic        wCtrl, wCmd, wFmode, wFdly, wTmode, wCnt;
  logic        wVset, wIset, wCur, wDwl, wTbl, wIdx;
  logic        clr, run, stop, msTick, paramWr, entry, fire;
  logic        stepDone, seqDone, fltBefore, fltAfter, programmed;
  logic [15:0] iClamp;
  logic [26:0] dClamp;
  logic [16:0] dlyQ;

  assign wCtrl  = regWr && regAddr == `OPTS_A_CTRL;
  assign wCmd   = regWr && regAddr == `OPTS_A_CMD;
  assign wFmode = regWr && regAddr == `OPTS_A_FMODE;
  assign wFdly  = regWr && regAddr == `OPTS_A_FDLY;
  assign wTmode = regWr && regAddr == `OPTS_A_TMODE;
  assign wCnt   = regWr && regAddr == `OPTS_A_COUNT;
  assign wVset  = regWr && regAddr == `OPTS_A_VSET;
  assign wIset  = regWr && regAddr == `OPTS_A_ISET;
  assign wCur   = regWr && regAddr == `OPTS_A_CURPT && st.len < 7'(DEPTH);
  assign wDwl   = regWr && regAddr == `OPTS_A_DWLPT && st.dwlLen < 7'(DEPTH);
  assign wTbl   = regWr && regAddr == `OPTS_A_TBLRST;
  assign wIdx   = regWr && regAddr == `OPTS_A_RDIDX;
  assign clr    = wCmd && regWdata[`OPTS_CMD_CLR];
  assign run    = wCmd && regWdata[`OPTS_CMD_RUN];
  assign stop   = wCmd && regWdata[`OPTS_CMD_STOP];
  assign msTick = st.msCnt == MS_CYCLES - 16'h1;
  assign paramWr = wCtrl || wVset || wIset;
  assign programmed = st.len != 7'h0;

  // Point limits applied on the way into the tables
  // Whole word compared so wide writes clamp instead of wrapping
  assign iClamp = regWdata > 32'(I_MAX) ? I_MAX : regWdata[15:0]; // RULE21
  assign dClamp = regWdata > 32'(`OPTS_DWELL_MAX) ? `OPTS_DWELL_MAX :
                  regWdata[26:0] < `OPTS_DWELL_MIN ? `OPTS_DWELL_MIN :
                  regWdata[26:0]; // RULE22
  // Nearest step; a tie rounds up
  assign dlyQ = 17'((regWdata[15:0] + 17'(`OPTS_HALF_MS)) / 17'(`OPTS_STEP_MS)); // RULE8

  function automatic logic [26:0] dwellAt(input logic [6:0] i, input logic [6:0] n,
                                          input logic [26:0] v);
    // Points past the dwell table hold for the shortest time
    dwellAt = i < n ? v : `OPTS_DWELL_MIN;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (wCur) begin
      curTbl[st.len] <= iClamp; // RULE20
    end
    if (wDwl) begin
      dwlTbl[st.dwlLen] <= dClamp; // RULE22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt = st;
    nxt.event_trigger_mode = 1'b0;
    nxt.rdata = 32'h0;
    fire = 1'b0;
    stepDone = 1'b0;
    seqDone = 1'b0;
    nxt.msCnt = msTick ? 16'h0 : st.msCnt + 16'h1;

    // Register writes
    if (wCtrl) begin
      nxt.outOn = regWdata[`OPTS_CTRL_OUT];
      nxt.recAuto = regWdata[`OPTS_CTRL_REC];
      nxt.user1 = regWdata[`OPTS_CTRL_U1];
      nxt.user2 = regWdata[`OPTS_CTRL_U2];
    end
    // Code 3 is not a mode; such writes are dropped
    if (wFmode && regWdata[1:0] != 2'h3) begin
      nxt.foldMode = regWdata[1:0]; // RULE5
    end
    if (wFdly) begin
      nxt.foldDly = (regWdata[31:16] != 16'h0 || dlyQ > 17'(`OPTS_DLY_MAX)) ? `OPTS_DLY_MAX :
                    dlyQ < 17'(`OPTS_DLY_MIN) ? `OPTS_DLY_MIN : dlyQ[7:0]; // RULE7
    end
    if (wTmode && regWdata[1:0] != 2'h3) begin
      nxt.trigMode = regWdata[1:0]; // RULE12
    end
    if (wCnt) begin
      nxt.endless = regWdata > 32'(`OPTS_CNT_MAX); // RULE17
      nxt.cnt = regWdata > 32'(`OPTS_CNT_MAX) ? `OPTS_CNT_MAX :
                regWdata == 32'h0 ? `OPTS_CNT_MIN : regWdata[13:0];
    end
    if (wVset) begin
      nxt.vSet = regWdata[15:0];
    end
    if (wIset) begin
      nxt.iSet = iClamp; // RULE21
    end
    if (wCur) begin
      nxt.len = st.len + 7'h1;
      nxt.otherZero = 1'b1; // RULE24
    end
    if (wDwl) begin
      nxt.dwlLen = st.dwlLen + 7'h1;
      nxt.waveTimeZero = 1'b1; // RULE24
    end
    if (wTbl) begin
      nxt.len = 7'h0;
      nxt.dwlLen = 7'h0;
      nxt.rdIdx = 7'h0;
    end
    if (wIdx) begin
      nxt.rdIdx = regWdata[6:0];
    end

    // Transition shutdown timer, counted from the entry event itself
    nxt.prevReg = regMode;
    entry = st.foldMode != `OPTS_FOLD_OFF && regMode == st.foldMode &&
            st.prevReg != st.foldMode;
    unique case (st.foldSt)
      opts_pkg::FOLD_IDLE: begin
        if (entry) begin
          nxt.foldSt = opts_pkg::FOLD_WAIT;
          nxt.foldCnt = st.foldDly;
          nxt.foldMs = 7'h0;
        end
      end
      opts_pkg::FOLD_WAIT: begin
        if (regMode != st.foldMode || st.foldMode == `OPTS_FOLD_OFF) begin
          nxt.foldSt = opts_pkg::FOLD_IDLE; // RULE9
        end else if (msTick) begin
          if (st.foldMs == 7'(`OPTS_STEP_MS - 1)) begin
            nxt.foldMs = 7'h0;
            nxt.foldCnt = st.foldCnt - 8'h1;
            if (st.foldCnt == 8'h1) begin
              fire = 1'b1; // RULE6
              nxt.foldSt = opts_pkg::FOLD_IDLE;
            end
          end else begin
            nxt.foldMs = st.foldMs + 7'h1;
          end
        end
      end
    endcase

    // Latches: a present condition or a new event beats the clear
    fltBefore = st.ovF || st.uvF || st.foldF;
    nxt.ovF = ovCond || (st.ovF && !clr); // RULE1 RULE2
    nxt.uvF = uvCond || (st.uvF && !clr); // RULE1 RULE2
    nxt.foldF = fire || (st.foldF && !clr); // RULE1 RULE6
    fltAfter = nxt.ovF || nxt.uvF || nxt.foldF;
    if (fltAfter && !fltBefore) begin
      nxt.prevOn = nxt.outOn;
      nxt.outOn = 1'b0;
    end else if (!fltAfter && fltBefore) begin
      nxt.outOn = st.recAuto && st.prevOn; // RULE3 RULE4
    end
    nxt.powerOn = nxt.outOn && !fltAfter; // RULE6

    // List sequencer
    unique case (st.seqSt)
      opts_pkg::SEQ_IDLE: begin
        if (run && programmed) begin
          nxt.seqSt = opts_pkg::SEQ_RUN;
          nxt.idx = 7'h0;
          nxt.pass = 14'h0;
          nxt.dwellCnt = dwellAt(7'h0, st.dwlLen, dwlTbl[0]);
        end
      end
      opts_pkg::SEQ_RUN: begin
        if (stop || wTbl) begin
          nxt.seqSt = opts_pkg::SEQ_IDLE;
        end else if (msTick) begin
          if (st.dwellCnt == 27'h1) begin
            stepDone = 1'b1; // RULE22
            if (st.idx == st.len - 7'h1) begin
              nxt.pass = st.pass + 14'h1; // RULE19
              if (!st.endless && st.pass + 14'h1 == st.cnt) begin
                seqDone = 1'b1;
                nxt.seqSt = opts_pkg::SEQ_IDLE;
              end else begin
                nxt.idx = 7'h0;
                nxt.dwellCnt = dwellAt(7'h0, st.dwlLen, dwlTbl[0]);
              end
            end else begin
              nxt.idx = st.idx + 7'h1;
              nxt.dwellCnt = dwellAt(st.idx + 7'h1, st.dwlLen, dwlTbl[st.idx + 7'h1]);
            end
          end else begin
            nxt.dwellCnt = st.dwellCnt - 27'h1;
          end
        end
      end
    endcase
    nxt.curSet = nxt.seqSt == opts_pkg::SEQ_RUN ? curTbl[nxt.idx] : nxt.iSet;

    // Trigger out
    unique case (st.trigMode)
      `OPTS_EVENT_TRIGGER_MODE_STB: nxt.event_trigger_mode = programmed ? stepDone : paramWr; // RULE14 RULE16
      `OPTS_EVENT_TRIGGER_MODE_EVT: nxt.event_trigger_mode = programmed ? seqDone :
                                 nxt.powerOn != st.powerOn; // RULE13 RULE15
      default:        nxt.event_trigger_mode = 1'b0;
    endcase

    // Open drain user outputs: enable low side when the bit is zero
    nxt.pins.oneOut = 1'b0;
    nxt.pins.twoOut = 1'b0;
    nxt.pins.oneOe = !nxt.user1; // RULE10
    nxt.pins.twoOe = !nxt.user2; // RULE11

    // Reads; table reads walk the read index
    if (regRd) begin
      unique case (regAddr)
        `OPTS_A_CTRL:   nxt.rdata = {28'h0, st.user2, st.user1, st.recAuto, st.outOn};
        `OPTS_A_FMODE:  nxt.rdata = {30'h0, st.foldMode};
        `OPTS_A_FDLY:   nxt.rdata = {24'h0, st.foldDly};
        `OPTS_A_TMODE:  nxt.rdata = {30'h0, st.trigMode};
        `OPTS_A_COUNT:  nxt.rdata = st.endless ? `OPTS_CNT_INF : {18'h0, st.cnt}; // RULE18
        `OPTS_A_VSET:   nxt.rdata = {16'h0, st.vSet};
        `OPTS_A_ISET:   nxt.rdata = {16'h0, st.iSet};
        `OPTS_A_CURPT: begin
          nxt.rdata = st.rdIdx < st.len ? {16'h0, curTbl[st.rdIdx]} : 32'h0; // RULE20
          nxt.rdIdx = st.rdIdx + 7'h1;
        end
        `OPTS_A_DWLPT: begin
          nxt.rdata = st.rdIdx < st.dwlLen ? {5'h0, dwlTbl[st.rdIdx]} : 32'h0;
          nxt.rdIdx = st.rdIdx + 7'h1;
        end
        `OPTS_A_TBLRST: nxt.rdata = {9'h0, st.dwlLen, 9'h0, st.len};
        `OPTS_A_RDIDX:  nxt.rdata = {25'h0, st.rdIdx};
        `OPTS_A_STATUS: nxt.rdata = {2'h0, st.pass, 4'h0, userPinIn, regMode,
                                     st.waveTimeZero, st.otherZero,
                                     st.foldSt == opts_pkg::FOLD_WAIT,
                                     st.seqSt == opts_pkg::SEQ_RUN,
                                     st.powerOn, st.foldF, st.uvF, st.ovF};
        default:        nxt.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
      st.user1 <= 1'b1;
      st.user2 <= 1'b1;
      st.foldDly <= `OPTS_DLY_MIN;
      st.cnt <= `OPTS_CNT_MIN;
    end else begin
      st <= nxt;
    end
  end

  assign regRdata = st.rdata;
  assign powerOn = st.powerOn;
  assign voltageSet = st.vSet;
  assign currentSet = st.curSet;
  assign trigOut = st.event_trigger_mode;
  assign userPins = st.pins;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_clear_release;
    clr && !ovCond && !uvCond && !fire |=> !st.ovF && !st.uvF && !st.foldF;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("clear left a latch"); // RULE1

  property p_latch_hold;
    ovCond ##1 clr |=> st.ovF || !$past(ovCond);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch freed under fault"); // RULE2

  property p_safe_recover;
    $fell(st.ovF || st.uvF || st.foldF) && !st.recAuto |-> !st.powerOn;
  endproperty
  a_safe_recover: assert property (p_safe_recover) else $error("safe recovery on"); // RULE4

  property p_fold_fire;
    st.foldSt == opts_pkg::FOLD_WAIT && st.foldMode != `OPTS_FOLD_OFF &&
    regMode == st.foldMode && msTick &&
    st.foldCnt == 8'h1 && st.foldMs == 7'(`OPTS_STEP_MS - 1)
    |=> st.foldF && !st.powerOn;
  endproperty
  a_fold_fire: assert property (p_fold_fire) else $error("shutdown missed"); // RULE6

  property p_fold_cancel;
    st.foldSt == opts_pkg::FOLD_WAIT && regMode != st.foldMode
    |=> st.foldSt == opts_pkg::FOLD_IDLE && !$rose(st.foldF);
  endproperty
  a_fold_cancel: assert property (p_fold_cancel) else $error("timer not cancelled"); // RULE9

  property p_round;
    wFdly && regWdata[15:0] == 16'h00FA |=> st.foldDly == 8'h03;
  endproperty
  a_round: assert property (p_round) else $error("delay rounding wrong"); // RULE8

  property p_user_one;
    userPins.oneOe == !st.user1 && !userPins.oneOut;
  endproperty
  a_user_one: assert property (p_user_one) else $error("user output one wrong"); // RULE10

  property p_endless;
    wCnt && regWdata > 32'h0000270F ##1 regRd && regAddr == `OPTS_A_COUNT
    |=> regRdata == `OPTS_CNT_INF;
  endproperty
  a_endless: assert property (p_endless) else $error("endless not shown"); // RULE18

  property p_strobe;
    st.trigMode == `OPTS_EVENT_TRIGGER_MODE_STB && !programmed && wVset |=> trigOut;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe missing"); // RULE14

  property p_seq_stop;
    seqDone |=> st.seqSt == opts_pkg::SEQ_IDLE && st.pass == st.cnt;
  endproperty
  a_seq_stop: assert property (p_seq_stop) else $error("sequence overran"); // RULE19

  c_fold: cover property (fire);
  c_recover_auto: cover property ($fell(st.foldF) && st.powerOn);
  c_seq_done: cover property (seqDone && st.trigMode == `OPTS_EVENT_TRIGGER_MODE_EVT);
endmodule

`default_nettype wire

// file: design/opts_defs.svh
`ifndef OPTS_DEFS_SVH
`define OPTS_DEFS_SVH
// Register offsets
`define OPTS_A_CTRL   8'h00
`define OPTS_A_CMD    8'h04
`define OPTS_A_FMODE  8'h08
`define OPTS_A_FDLY   8'h0C
`define OPTS_A_TMODE  8'h10
`define OPTS_A_COUNT  8'h14
`define OPTS_A_VSET   8'h18
`define OPTS_A_ISET   8'h1C
`define OPTS_A_CURPT  8'h20
`define OPTS_A_DWLPT  8'h24
`define OPTS_A_TBLRST 8'h28
`define OPTS_A_RDIDX  8'h2C
`define OPTS_A_STATUS 8'h30
// Field positions
`define OPTS_CTRL_OUT 0
`define OPTS_CTRL_REC 1
`define OPTS_CTRL_U1  2
`define OPTS_CTRL_U2  3
`define OPTS_CMD_CLR  0
`define OPTS_CMD_RUN  1
`define OPTS_CMD_STOP 2
// Mode codes; regulation input uses the fold codes
`define OPTS_FOLD_OFF 2'h0
`define OPTS_FOLD_CURR 2'h1
`define OPTS_FOLD_VOLT 2'h2
`define OPTS_EVENT_TRIGGER_MODE_OFF 2'h0
`define OPTS_EVENT_TRIGGER_MODE_STB 2'h1
`define OPTS_EVENT_TRIGGER_MODE_EVT 2'h2
// Reset values and limits
`define OPTS_DLY_MIN   8'h01
`define OPTS_DLY_MAX   8'hFF
`define OPTS_CNT_MIN   14'h0001
`define OPTS_CNT_MAX   14'h270F
`define OPTS_CNT_INF   32'hFFFFFFFF
`define OPTS_DWELL_MIN 27'h0000001
`define OPTS_DWELL_MAX 27'h7B98A00
// Timing
`define OPTS_CLK_NS    20
`define OPTS_MS_NS     1000000
`define OPTS_STEP_MS   100
`define OPTS_HALF_MS   50
`endif

// file: design/opts_pkg.sv
package opts_pkg;
  typedef enum logic {FOLD_IDLE, FOLD_WAIT} opts_fold_t;
  typedef enum logic {SEQ_IDLE, SEQ_RUN} opts_seq_t;

  typedef struct packed {
    logic oneOut;
    logic oneOe;
    logic twoOut;
    logic twoOe;
  } opts_pins_t;

  typedef struct packed {
    logic        outOn;
    logic        prevOn;
    logic        powerOn;
    logic        recAuto;
    logic        user1;
    logic        user2;
    logic        ovF;
    logic        uvF;
    logic        foldF;
    logic [1:0]  foldMode;
    logic [7:0]  foldDly;
    opts_fold_t  foldSt;
    logic [7:0]  foldCnt;
    logic [6:0]  foldMs;
    logic [1:0]  prevReg;
    logic [1:0]  trigMode;
    logic        event_trigger_mode;
    logic [13:0] cnt;
    logic        endless;
    logic [15:0] vSet;
    logic [15:0] iSet;
    logic [15:0] curSet;
    opts_seq_t   seqSt;
    logic [6:0]  idx;
    logic [6:0]  len;
    logic [6:0]  dwlLen;
    logic [6:0]  rdIdx;
    logic [26:0] dwellCnt;
    logic [13:0] pass;
    logic [15:0] msCnt;
    logic        otherZero;
    logic        waveTimeZero;
    opts_pins_t  pins;
    logic [31:0] rdata;
  } opts_state_t;
endpackage

// file: sim/opts_stage_model.sv
`timescale 1ns/10ps
`default_nettype none

module opts_stage_model (
  // Clock
  input  wire logic                  clk_sys,
  // Bench controls
  input  wire logic [1:0]            wantMode,
  input  wire logic                  wantOv,
  input  wire logic                  wantUv,
  // Device side
  input  wire logic                  powerOn,
  input  wire opts_pkg::opts_pins_t  userPins,
  output logic [1:0]                 regMode,
  output logic                       ovCond,
  output logic                       uvCond,
  output logic [1:0]                 userPinIn
);
  // No regulation mode exists while the output is off
  always_ff @(posedge clk_sys) begin
    regMode <= powerOn ? wantMode : 2'h0;
    ovCond  <= wantOv;
    uvCond  <= wantUv;
  end

  // Open-drain pins with pull-ups: released pins read high
  assign userPinIn[0] = userPins.oneOe ? userPins.oneOut : 1'b1;
  assign userPinIn[1] = userPins.twoOe ? userPins.twoOut : 1'b1;
endmodule

`default_nettype wire

// file: sim/test_opts_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "opts_defs.svh"

module test_opts_core;
  localparam logic [15:0] IMAX = 16'h03E8;

  logic                 clk_sys;
  logic                 rst_n;
  logic [7:0]           regAddr;
  logic [31:0]          regWdata;
  logic                 regWr;
  logic                 regRd;
  logic [31:0]          regRdata;
  logic [1:0]           regMode;
  logic                 ovCond;
  logic                 uvCond;
  logic                 powerOn;
  logic [15:0]          voltageSet;
  logic [15:0]          currentSet;
  logic                 trigOut;
  logic [1:0]           userPinIn;
  opts_pkg::opts_pins_t userPins;
  logic [1:0]           wantMode;
  logic                 wantOv;
  logic                 wantUv;
  int                   numErrors;
  int                   checked;
  int                   trigCnt;
  int                   cycles;

  // Millisecond prescaler shortened so delays fit the run
  opts_core #(.I_MAX(IMAX), .MS_CYCLES(16'h000A)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ovCond(ovCond),
    .uvCond(uvCond), .regMode(regMode), .powerOn(powerOn), .voltageSet(voltageSet),
    .currentSet(currentSet), .trigOut(trigOut), .userPinIn(userPinIn),
    .userPins(userPins));

  opts_stage_model stage_u (
    .clk_sys(clk_sys), .wantMode(wantMode), .wantOv(wantOv), .wantUv(wantUv),
    .powerOn(powerOn), .userPins(userPins), .regMode(regMode), .ovCond(ovCond),
    .uvCond(uvCond), .userPinIn(userPinIn));

  always #10 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse counting avoids guessing the exact pulse cycle
  always @(posedge clk_sys) begin
    if (trigOut === 1'b1) begin
      trigCnt++;
    end
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      endOfTest();
    end
  end

  task automatic endOfTest();
    $display("checks %0d errors %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Read data are taken at the edge that ends their only valid cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(posedge clk_sys);
    d = regRdata;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask

  task automatic sbit(input string n, input int p, input logic e);
    logic [31:0] d;
    rd(`OPTS_A_STATUS, d);
    chk(n, {31'h0, e}, {31'h0, d[p]});
  endtask

  function automatic logic [31:0] dlyOf(input int ms);
    int s;
    s = (ms + 50) / 100;
    if (s < 1) s = 1;
    if (s > 255) s = 255;
    return 32'(s);
  endfunction

  function automatic logic [31:0] cntOf(input logic [31:0] v);
    if (v > 32'h0000270F) return 32'hFFFFFFFF;
    if (v == 32'h0) return 32'h1;
    return v;
  endfunction

  function automatic logic [15:0] iClamp(input logic [15:0] v);
    return (v > IMAX) ? IMAX : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [31:0] w;
    logic [15:0] cp [3];
    int          dl [5];
    int          t0;
    int          n;
    clk_sys = 1'b0;
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    wantMode = 2'h0;
    wantOv = 1'b0;
    wantUv = 1'b0;
    v = $urandom(32'h15ECD13C);
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rchk("fdlyReset", `OPTS_A_FDLY, 32'h1);
    rchk("countReset", `OPTS_A_COUNT, 32'h1);
    rchk("ctrlReset", `OPTS_A_CTRL, 32'hC);
    rchk("unmapped", 8'h3C, 32'h0);
    rchk("cmdRead", `OPTS_A_CMD, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`OPTS_A_CTRL, {28'h0, i[1:0], 2'h0});
      chk("oneOe", {31'h0, ~i[0]}, {31'h0, userPins.oneOe});
      chk("twoOe", {31'h0, ~i[1]}, {31'h0, userPins.twoOe});
      chk("pins", {30'h0, i[1:0]}, {30'h0, userPinIn});
      rchk("ctrlBits", `OPTS_A_CTRL, {28'h0, i[1:0], 2'h0});
    end
    // Trigger modes with no table loaded
    for (int m = 0; m < 3; m++) begin
      wr(`OPTS_A_TMODE, 32'(m));
      rchk("tmode", `OPTS_A_TMODE, 32'(m));
      t0 = trigCnt;
      v = $urandom;
      w = $urandom;
      wr(`OPTS_A_VSET, {16'h0, v[15:0]});
      wr(`OPTS_A_ISET, {16'h0, w[15:0]});
      cyc(2);
      chk("vset", {16'h0, v[15:0]}, {16'h0, voltageSet});
      chk("iset", {16'h0, iClamp(w[15:0])}, {16'h0, currentSet});
      chk("strobes", 32'(t0 + ((m == 1) ? 2 : 0)), 32'(trigCnt));
    end
    wr(`OPTS_A_TMODE, 32'h3);
    rchk("tmodeBad", `OPTS_A_TMODE, 32'h2);
    t0 = trigCnt;
    wr(`OPTS_A_CTRL, 32'hF);
    cyc(3);
    chk("outOn", 32'h1, {31'h0, powerOn});
    chk("event", 32'(t0 + 1), 32'(trigCnt));
    // Latched faults and recovery
    wantOv <= 1'b1;
    cyc(3);
    chk("ovOff", 32'h0, {31'h0, powerOn});
    wr(`OPTS_A_CMD, 32'h1);
    sbit("ovHeld", 0, 1'b1);
    wantOv <= 1'b0;
    cyc(3);
    wr(`OPTS_A_CMD, 32'h1);
    chk("autoOn", 32'h1, {31'h0, powerOn});
    sbit("ovClr", 0, 1'b0);
    wr(`OPTS_A_CTRL, 32'hD);
    wantUv <= 1'b1;
    cyc(3);
    sbit("uvSet", 1, 1'b1);
    wantUv <= 1'b0;
    cyc(3);
    wr(`OPTS_A_CMD, 32'h1);
    chk("safeOff", 32'h0, {31'h0, powerOn});
    sbit("uvClr", 1, 1'b0);
    // Transition shutdown
    for (int m = 0; m < 4; m++) begin
      wr(`OPTS_A_FMODE, 32'(m));
      rchk("fmode", `OPTS_A_FMODE, 32'((m == 3) ? 2 : m));
    end
    dl = '{0, 149, 150, 2549, 60000};
    foreach (dl[k]) begin
      wr(`OPTS_A_FDLY, 32'(dl[k]));
      rchk("fdly", `OPTS_A_FDLY, dlyOf(dl[k]));
    end
    wr(`OPTS_A_FDLY, 32'd250);
    rchk("fdlyTie", `OPTS_A_FDLY, dlyOf(250));
    wr(`OPTS_A_FDLY, 32'd100);
    wr(`OPTS_A_CTRL, 32'hF);
    wantMode <= 2'h2;
    cyc(500);
    wantMode <= 2'h1;
    cyc(800);
    chk("cancelOn", 32'h1, {31'h0, powerOn});
    sbit("cancelNoFault", 2, 1'b0);
    wantMode <= 2'h2;
    n = 0;
    while (powerOn === 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    // 100 ms at 10 cycles per ms, tick may land up to 1 ms early
    chk("foldTime", 32'h1, {31'h0, (n >= 985 && n <= 1006)});
    sbit("foldLatch", 2, 1'b1);
    wantMode <= 2'h0;
    wr(`OPTS_A_FMODE, 32'h0);
    wr(`OPTS_A_CMD, 32'h1);
    sbit("foldClr", 2, 1'b0);
    // Iteration counter
    dl = '{0, 9999, 10000, int'($urandom_range(9999, 1)), int'($urandom_range(90000, 10001))};
    foreach (dl[k]) begin
      wr(`OPTS_A_COUNT, 32'(dl[k]));
      rchk("count", `OPTS_A_COUNT, cntOf(32'(dl[k])));
    end
    // Write strobe followed at once by a read strobe
    regAddr  <= `OPTS_A_COUNT;
    regWdata <= 32'd20000;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(posedge clk_sys);
    chk("countB2B", 32'hFFFFFFFF, regRdata);
    // Tables and sequencer
    wr(`OPTS_A_TBLRST, 32'h0);
    wr(`OPTS_A_TMODE, 32'h1);
    v = $urandom;
    cp = '{16'h0100, 16'hFFFF, 16'(v[9:0])};
    for (int i = 0; i < 3; i++) begin
      wr(`OPTS_A_CURPT, {16'h0, cp[i]});
      wr(`OPTS_A_DWLPT, 32'(i + 2));
    end
    cyc(1000);
    rchk("tblLen", `OPTS_A_TBLRST, 32'h00030003);
    sbit("otherZero", 6, 1'b1);
    sbit("waveTimeZero", 7, 1'b1);
    for (int i = 0; i < 3; i++) begin
      rchk("curPoint", `OPTS_A_CURPT, {16'h0, iClamp(cp[i])});
    end
    wr(`OPTS_A_COUNT, 32'h2);
    t0 = trigCnt;
    wr(`OPTS_A_CMD, 32'h2);
    chk("seqPoint", 32'h100, {16'h0, currentSet});
    cyc(60);
    sbit("seqRunning", 4, 1'b1);
    cyc(240);
    chk("stepPulses", 32'(t0 + 6), 32'(trigCnt));
    sbit("seqDone", 4, 1'b0);
    rd(`OPTS_A_STATUS, v);
    chk("passCount", 32'h2, {18'h0, v[29:16]});
    chk("seqIdle", {16'h0, iClamp(w[15:0])}, {16'h0, currentSet});
    wr(`OPTS_A_TMODE, 32'h2);
    t0 = trigCnt;
    wr(`OPTS_A_CMD, 32'h2);
    cyc(300);
    chk("endPulse", 32'(t0 + 1), 32'(trigCnt));
    endOfTest();
  end
endmodule

`default_nettype wire
